//--- verilog/usb_host_token_regs.sv
/*
 * host token command, frame number capture, frame marker threshold and
 * descriptor table base registers of a full-speed usb controller.
 * assumes a packet engine that reports received frame markers with
 * their frame number, accepts token launches and pulses done on completion.
 */
`include "usb_tok_defs.svh"

module usb_host_token_regs
#(
   parameter int SOF_PERIOD_CYCLES = `SOF_PERIOD_NS / `CLK_PERIOD_NS,
   parameter int FS_BYTE_CYCLES = (`FS_BYTE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int LS_BYTE_CYCLES = (`LS_BYTE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // register port
   input wire usb_tok_pkg::reg_req_t req,
   output logic [31:0] rdata,
   // received frame marker from the packet engine (device mode)
   input wire logic sof_seen,
   input wire logic [10:0] sof_frame,
   // token launch to the packet engine
   output usb_tok_pkg::token_cmd_t token,
   output logic token_launch,
   input wire logic token_done,
   // frame marker launch (host mode)
   output logic sof_send,
   output logic [10:0] sof_number,
   // status
   output logic token_in_progress
);
   import usb_tok_pkg::*;

   // =========================================================
   // elaboration checks
   if (SOF_PERIOD_CYCLES < 2 || FS_BYTE_CYCLES < 1 || LS_BYTE_CYCLES < FS_BYTE_CYCLES)
      $error("unusable timing parameters");

   localparam int CW = $clog2(SOF_PERIOD_CYCLES + 1);
   // guard product is wide enough for a full threshold of low speed byte times
   localparam int BW = $clog2(LS_BYTE_CYCLES + 1);
   localparam int GW = (CW > BW + 8) ? CW : BW + 8;

   // =========================================================
   // register state
   logic [7:0] frame_count_lower_q;
   logic [`FRAME_HIGH_BITS-1:0] frame_count_upper_q;
   logic [3:0] token_type_q;
   logic [3:0] token_endpoint_number_q;
   logic [7:0] sof_guard_count_q;
   logic [6:0] table_base_bits_15_9_q;
   logic [7:0] table_base_bits_23_16_q;
   logic [7:0] table_base_bits_31_24_q;
   logic host_enable_q;
   logic frame_marker_enable_q;
   logic next_token_low_speed_q;
   logic [6:0] device_address_q;
   logic [CW-1:0] frame_timer_q;
   logic [10:0] host_frame_q;
   logic [31:0] rdata_q;
   logic token_write;
   logic room_ok;
   logic [GW-1:0] guard_cycles;
   logic [GW-1:0] remain_cycles;
   logic [CW-1:0] marker_gap_q;
   logic seq_launch;
   logic seq_busy;

   assign token_write = req.wr && (req.addr == `OFS_TOKEN_CMD);

   // =========================================================
   // token command register; a write while busy is ignored so an executing
   // token is never corrupted by software that skipped the busy check
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         token_type_q <= 4'h0;
         token_endpoint_number_q <= 4'h0;
      end
      else if (token_write && !seq_busy)
      begin
         token_type_q <= req.wdata[`TOK_TYPE_HI:`TOK_TYPE_LO];
         token_endpoint_number_q <= req.wdata[`TOK_EP_HI:`TOK_EP_LO];
      end
   end

   // threshold and descriptor table base registers
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         sof_guard_count_q <= `RST_BYTE;
         table_base_bits_15_9_q <= 7'h00;
         table_base_bits_23_16_q <= `RST_BYTE;
         table_base_bits_31_24_q <= `RST_BYTE;
      end
      else if (req.wr)
      begin
         case (req.addr)
            `OFS_SOF_THRESH: sof_guard_count_q <= req.wdata[7:0];
            `OFS_BASE_LOW: table_base_bits_15_9_q <= req.wdata[7:1];
            `OFS_BASE_MID: table_base_bits_23_16_q <= req.wdata[7:0];
            `OFS_BASE_TOP: table_base_bits_31_24_q <= req.wdata[7:0];
            default: ;
         endcase
      end
   end

   // host control: enable, frame marker enable, speed and device address
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         host_enable_q <= 1'b0;
         frame_marker_enable_q <= 1'b0;
         next_token_low_speed_q <= 1'b0;
         device_address_q <= 7'h00;
      end
      else if (req.wr && req.addr == `OFS_HOST_CTRL)
      begin
         host_enable_q <= req.wdata[`CTRL_HOST_EN];
         frame_marker_enable_q <= req.wdata[`CTRL_SOF_EN];
      end
      else if (req.wr && req.addr == `OFS_HOST_ADDR)
      begin
         next_token_low_speed_q <= req.wdata[`ADDR_LOW_SPEED];
         device_address_q <= req.wdata[6:0];
      end
   end

   // =========================================================
   // frame number capture; in host mode the sent marker's number is taken
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         frame_count_lower_q <= `RST_BYTE;
         frame_count_upper_q <= 3'h0;
      end
      else if (sof_seen)
      begin
         frame_count_lower_q <= sof_frame[7:0];
         frame_count_upper_q <= sof_frame[10:8];
      end
      else if (sof_send)
      begin
         frame_count_lower_q <= host_frame_q[7:0];
         frame_count_upper_q <= host_frame_q[10:8];
      end
   end

   // =========================================================
   // millisecond frame timer; counts down to the next marker
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         frame_timer_q <= CW'(SOF_PERIOD_CYCLES - 1);
         host_frame_q <= 11'h000;
      end
      else if (!(host_enable_q && frame_marker_enable_q))
         frame_timer_q <= CW'(SOF_PERIOD_CYCLES - 1);
      else if (frame_timer_q == '0)
      begin
         frame_timer_q <= CW'(SOF_PERIOD_CYCLES - 1);
         host_frame_q <= host_frame_q + 11'h001;
      end
      else
         frame_timer_q <= frame_timer_q - 1'b1;
   end

   assign sof_send = host_enable_q && frame_marker_enable_q && (frame_timer_q == '0);
   assign sof_number = host_frame_q;

   // spacing count kept apart from the down counter, so that a wrong reload
   // value in the timer shows up in the period check below
   always_ff @(posedge clock)
   begin
      if (!rstn)
         marker_gap_q <= '0;
      else if (!(host_enable_q && frame_marker_enable_q) || sof_send)
         marker_gap_q <= '0;
      else
         marker_gap_q <= marker_gap_q + 1'b1;
   end

   // =========================================================
   // guard window: threshold byte times at the speed of the next token;
   // without frame markers there is no window to protect. the check is made
   // two cycles before the token reaches the engine, so that lag is added
   // to the window rather than eaten out of it
   assign guard_cycles = GW'(sof_guard_count_q) *
      (next_token_low_speed_q ? GW'(LS_BYTE_CYCLES) : GW'(FS_BYTE_CYCLES));
   assign remain_cycles = GW'(frame_timer_q);
   assign room_ok = !(host_enable_q && frame_marker_enable_q) ||
      (remain_cycles >= guard_cycles + GW'(`LAUNCH_LAG_CYCLES));

   token_sequencer u_seq (
      .clock(clock),
      .rstn(rstn),
      .start(token_write && !seq_busy),
      .room_ok(room_ok),
      .engine_done(token_done),
      .launch(seq_launch),
      .busy(seq_busy)
   );

   // token handed to the engine; the type code passes unchanged, so a
   // reserved code written by software reaches the engine as it stands
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         token <= '0;
         token_launch <= 1'b0;
      end
      else
      begin
         token_launch <= seq_launch;
         if (seq_launch)
         begin
            token.pid <= token_type_q;
            token.endpoint <= token_endpoint_number_q;
            token.dev_addr <= device_address_q;
            token.low_speed <= next_token_low_speed_q;
            token.table_base <= {table_base_bits_31_24_q, table_base_bits_23_16_q,
               table_base_bits_15_9_q, {`TABLE_ALIGN_BITS{1'b0}}};
         end
      end
   end

   // software polls this through the status word before the next token write
   assign token_in_progress = seq_busy;

   // =========================================================
   // read port: data one cycle after the strobe, zero otherwise
   always_ff @(posedge clock)
   begin
      if (!rstn)
         rdata_q <= `RST_WORD;
      else if (!req.rd)
         rdata_q <= `RST_WORD;
      else
      begin
         case (req.addr)
            `OFS_FRAME_LOW: rdata_q <= {24'h0, frame_count_lower_q};
            `OFS_FRAME_HIGH: rdata_q <= {29'h0, frame_count_upper_q};
            `OFS_TOKEN_CMD: rdata_q <= {24'h0, token_type_q, token_endpoint_number_q};
            `OFS_SOF_THRESH: rdata_q <= {24'h0, sof_guard_count_q};
            `OFS_BASE_LOW: rdata_q <= {24'h0, table_base_bits_15_9_q, 1'b0};
            `OFS_BASE_MID: rdata_q <= {24'h0, table_base_bits_23_16_q};
            `OFS_BASE_TOP: rdata_q <= {24'h0, table_base_bits_31_24_q};
            `OFS_HOST_CTRL: rdata_q <= {30'h0, frame_marker_enable_q, host_enable_q};
            `OFS_HOST_ADDR: rdata_q <= {24'h0, next_token_low_speed_q, device_address_q};
            `OFS_HOST_STATUS: rdata_q <= {31'h0, seq_busy};
            default: rdata_q <= `RST_WORD;
         endcase
      end
   end

   assign rdata = rdata_q;

   // =========================================================
   // checks
   // register map and field checks
   chk_frame_capture: assert property (@(posedge clock) disable iff (!rstn)
      sof_seen |=> {frame_count_upper_q, frame_count_lower_q} == $past(sof_frame))
      else $error("frame number not captured on marker");
   chk_frame_hold: assert property (@(posedge clock) disable iff (!rstn)
      (!sof_seen && !sof_send) |=> $stable({frame_count_upper_q, frame_count_lower_q}))
      else $error("frame number changed without a marker");
   chk_upper_read: assert property (@(posedge clock) disable iff (!rstn)
      (req.rd && req.addr == `OFS_FRAME_HIGH) |=> rdata[31:3] == 29'h0)
      else $error("upper frame register high bits not zero");
   chk_lower_read: assert property (@(posedge clock) disable iff (!rstn)
      (req.rd && req.addr == `OFS_FRAME_LOW) |=> rdata[31:8] == 24'h0)
      else $error("lower frame register high bits not zero");
   chk_base_align: assert property (@(posedge clock) disable iff (!rstn)
      token_launch |-> token.table_base[8:0] == 9'h000)
      else $error("table base not aligned");
   chk_base_low_bit: assert property (@(posedge clock) disable iff (!rstn)
      (req.rd && req.addr == `OFS_BASE_LOW) |=> rdata[0] == 1'b0)
      else $error("base low bit zero reads as one");
   chk_token_fields: assert property (@(posedge clock) disable iff (!rstn)
      (token_write && !seq_busy) |=> token_type_q == $past(req.wdata[7:4])
         && token_endpoint_number_q == $past(req.wdata[3:0]))
      else $error("token fields not stored");
   chk_token_hold: assert property (@(posedge clock) disable iff (!rstn)
      (token_write && seq_busy) |=> $stable({token_type_q, token_endpoint_number_q}))
      else $error("token overwritten while busy");
   chk_thresh_store: assert property (@(posedge clock) disable iff (!rstn)
      (req.wr && req.addr == `OFS_SOF_THRESH) |=> sof_guard_count_q == $past(req.wdata[7:0]))
      else $error("threshold not stored");
   chk_read_idle: assert property (@(posedge clock) disable iff (!rstn)
      !req.rd |=> rdata == 32'h0)
      else $error("read data not zero outside a read");

   // token flow and frame timing checks
   chk_sof_period: assert property (@(posedge clock) disable iff (!rstn)
      sof_send |=> !sof_send)
      else $error("frame markers back to back");
   chk_sof_spacing: assert property (@(posedge clock) disable iff (!rstn)
      (host_enable_q && frame_marker_enable_q) |-> sof_send == (marker_gap_q == CW'(SOF_PERIOD_CYCLES - 1)))
      else $error("frame marker spacing not one period");
   chk_launch_busy: assert property (@(posedge clock) disable iff (!rstn)
      token_launch |-> token_in_progress)
      else $error("launch without busy indication");
   chk_launch_pulse: assert property (@(posedge clock) disable iff (!rstn)
      token_launch |=> !token_launch)
      else $error("token launch longer than one cycle");
   chk_type_pass: assert property (@(posedge clock) disable iff (!rstn)
      seq_launch |=> token.pid == $past(token_type_q) && token.endpoint == $past(token_endpoint_number_q))
      else $error("token type or endpoint not handed on");
   chk_speed_follow: assert property (@(posedge clock) disable iff (!rstn)
      seq_launch |=> token.low_speed == $past(next_token_low_speed_q))
      else $error("token speed not taken from low speed bit");
   chk_mid_top: assert property (@(posedge clock) disable iff (!rstn)
      seq_launch |=> token.table_base[31:16] == $past({table_base_bits_31_24_q, table_base_bits_23_16_q}))
      else $error("table base upper bits wrong");

endmodule

//--- verilog/usb_tok_defs.svh
/*
 * register offsets, field positions, reset values and timing constants
 * for the host token, frame number and descriptor table base registers.
 * assumes it is included once per compilation unit by its bare name.
 */
`ifndef USB_TOK_DEFS_SVH
`define USB_TOK_DEFS_SVH

// =========================================================
// register offsets (byte addresses, one word each)
`define OFS_FRAME_LOW      8'h00
`define OFS_FRAME_HIGH     8'h04
`define OFS_TOKEN_CMD      8'h08
`define OFS_SOF_THRESH     8'h0c
`define OFS_BASE_LOW       8'h10
`define OFS_BASE_MID       8'h14
`define OFS_BASE_TOP       8'h18
`define OFS_HOST_CTRL      8'h1c
`define OFS_HOST_ADDR      8'h20
`define OFS_HOST_STATUS    8'h24

// =========================================================
// field positions
`define TOK_TYPE_HI        7
`define TOK_TYPE_LO        4
`define TOK_EP_HI          3
`define TOK_EP_LO          0
`define CTRL_HOST_EN       0
`define CTRL_SOF_EN        1
`define ADDR_LOW_SPEED     7
`define FRAME_HIGH_BITS    3

// =========================================================
// packet type codes
`define TOK_TYPE_OUT       4'h1
`define TOK_TYPE_IN        4'h9
`define TOK_TYPE_SETUP     4'hd
`define SOF_PID            4'h5

// =========================================================
// reset values
`define RST_BYTE           8'h00
`define RST_WORD           32'h0000_0000

// =========================================================
// timing and descriptor table alignment
`define CLK_PERIOD_NS      5
`define SOF_PERIOD_NS      1000000
`define FS_BYTE_NS         667
`define LS_BYTE_NS         5333
`define TABLE_ALIGN_BITS   9
`define LAUNCH_LAG_CYCLES  2

`endif

//--- verilog/usb_tok_pkg.sv
/*
 * types shared by the token register block and its transaction sequencer.
 * assumes usb_tok_defs.svh supplies the numeric constants.
 */
package usb_tok_pkg;

   // =========================================================
   // register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // token launch to the packet engine
   typedef struct packed {
      logic [3:0] pid;
      logic [3:0] endpoint;
      logic [6:0] dev_addr;
      logic low_speed;
      logic [31:0] table_base;
   } token_cmd_t;

   // sequencer states
   typedef enum logic [1:0] {
      seq_idle,
      seq_wait_room,
      seq_issue,
      seq_busy
   } seq_state_t;

endpackage

//--- verilog/token_sequencer.sv
/*
 * holds a token until there is room before the next frame marker, hands it
 * to the packet engine and keeps the busy indication until the engine is done.
 * assumes the packet engine raises done for one cycle per accepted token.
 */
module token_sequencer
(
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // control
   input wire logic start,
   input wire logic room_ok,
   input wire logic engine_done,
   // status
   output logic launch,
   output logic busy
);
   import usb_tok_pkg::*;

   seq_state_t state_q;
   seq_state_t state_d;

   // =========================================================
   // next state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         seq_idle:
         begin
            if (start)
               state_d = seq_wait_room;
         end
         seq_wait_room:
         begin
            if (room_ok)
               state_d = seq_issue;
         end
         seq_issue:
            state_d = seq_busy;
         seq_busy:
         begin
            if (engine_done)
               state_d = seq_idle;
         end
         default:
            state_d = seq_idle;
      endcase
   end

   // state register
   always_ff @(posedge clock)
   begin
      if (!rstn)
         state_q <= seq_idle;
      else
         state_q <= state_d;
   end

   // busy from write until completion, launch for one cycle
   assign busy = (state_q != seq_idle);
   assign launch = (state_q == seq_issue);

   // =========================================================
   // checks
   chk_launch_room: assert property (@(posedge clock) disable iff (!rstn)
      launch |-> $past(room_ok))
      else $error("token launched without room before frame marker");
   chk_busy_start: assert property (@(posedge clock) disable iff (!rstn)
      (start && !busy) |=> busy)
      else $error("busy not raised after token write");

endmodule

//--- verification/usb_engine_model.sv
/*
 * behavioural packet engine standing at the far side of the token block:
 * takes token launches, answers done after a chosen delay, reports markers.
 * assumes one clock and a synchronous active low reset shared with the block.
 */
module usb_engine_model
(
   // clock and reset
   input wire logic clock,
   input wire logic rstn,
   // token side
   input wire usb_tok_pkg::token_cmd_t token,
   input wire logic token_launch,
   input wire logic [7:0] done_delay,
   output logic token_done,
   // received frame markers
   output logic sof_seen,
   output logic [10:0] sof_frame,
   // observation
   output usb_tok_pkg::token_cmd_t last_tok,
   output logic [7:0] launch_count
);
   timeunit 1ns;
   timeprecision 1ps;
   import usb_tok_pkg::*;
   logic [7:0] wait_q;
   logic active_q;

   // =========================================================
   // transaction timing: delay set per token, so both quick and slow answers occur
   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         token_done <= 1'b0;
         active_q <= 1'b0;
         wait_q <= 8'h00;
         last_tok <= '0;
         launch_count <= 8'h00;
      end
      else
      begin
         token_done <= 1'b0;
         if (token_launch)
         begin
            last_tok <= token;
            launch_count <= launch_count + 8'h01;
            active_q <= 1'b1;
            wait_q <= done_delay;
         end
         else if (active_q && wait_q == 8'h00)
         begin
            token_done <= 1'b1;
            active_q <= 1'b0;
         end
         else if (active_q)
         begin
            wait_q <= wait_q - 8'h01;
         end
      end
   end

   // =========================================================
   // frame marker; number is scrambled outside the pulse so stale data never matches
   initial
   begin
      sof_seen = 1'b0;
      sof_frame = 11'h2aa;
   end

   task automatic send_marker(input logic [10:0] n);
      @(posedge clock);
      sof_seen <= 1'b1;
      sof_frame <= n;
      @(posedge clock);
      sof_seen <= 1'b0;
      sof_frame <= ~n;
   endtask
endmodule

//--- verification/usb_host_token_regs_tb.sv
/*
 * self-checking bench for the host token register block.
 * assumes the engine model answers tokens and the period is shortened to 400.
 */
`include "usb_tok_defs.svh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin err_total++; \
   $display("mismatch %s expected %h seen %h", nm, exp, got); end end

module usb_host_token_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import usb_tok_pkg::*;
   logic clock;
   logic rstn;
   reg_req_t req;
   logic [31:0] rdata;
   logic sof_seen;
   logic [10:0] sof_frame;
   token_cmd_t token;
   token_cmd_t last_tok;
   logic token_launch;
   logic token_done;
   logic sof_send;
   logic [10:0] sof_number;
   logic token_in_progress;
   logic [7:0] done_delay;
   logic [7:0] launch_count;
   logic [31:0] rd_val;
   logic [7:0] thr [4] = '{8'h4a, 8'h2a, 8'h1a, 8'h12};
   logic [3:0] pids [3] = '{`TOK_TYPE_OUT, `TOK_TYPE_IN, `TOK_TYPE_SETUP};
   logic [3:0] eps [3] = '{4'h0, 4'h7, 4'hf};
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   int sof_pulses = 0;
   int p0;

   // =========================================================
   // clock, cycle limit and marker counting
   always #2.5 clock = ~clock;

   always @(posedge clock)
   begin
      cycles++;
      if (sof_send === 1'b1)
         sof_pulses++;
      if (cycles == 20000)
      begin
         $display("mismatch cycle limit expected below %0d seen %0d", 20000, cycles);
         err_total++;
         report_and_stop();
      end
   end

   usb_host_token_regs #(.SOF_PERIOD_CYCLES(400)) uut (.clock(clock), .rstn(rstn), .req(req), .rdata(rdata),
      .sof_seen(sof_seen), .sof_frame(sof_frame), .token(token), .token_launch(token_launch),
      .token_done(token_done), .sof_send(sof_send), .sof_number(sof_number),
      .token_in_progress(token_in_progress));

   usb_engine_model eng (.clock(clock), .rstn(rstn), .token(token), .token_launch(token_launch),
      .done_delay(done_delay), .token_done(token_done), .sof_seen(sof_seen), .sof_frame(sof_frame),
      .last_tok(last_tok), .launch_count(launch_count));

   // =========================================================
   // register port tasks: one strobe cycle, read data the cycle after
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clock);
      req.wr <= 1'b0;
   endtask

   task automatic check_reg(input string nm, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clock);
      req.rd <= 1'b0;
      #1;
      rd_val = rdata;
      `CHK(nm, exp, rd_val)
   endtask

   // software waits here, up to 3000 cycles, until the running token is done
   task automatic wait_idle();
      for (int n = 0; n < 3000 && token_in_progress !== 1'b0; n++)
         @(posedge clock);
      `CHK("idle wait", 1'b0, token_in_progress)
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // =========================================================
   // main sequence
   initial
   begin
      clock = 1'b0;
      rstn = 1'b0;
      req = '0;
      done_delay = 8'h04;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      // every register and one unmapped place read zero after reset
      for (int i = 0; i < 10; i++)
         check_reg("reset value", 8'(i * 4), 32'h0);
      reg_write(8'h40, 32'hffff_ffff);
      check_reg("unmapped", 8'h40, 32'h0);
      // recommended thresholds, upper bits dropped
      foreach (thr[i])
      begin
         reg_write(`OFS_SOF_THRESH, {24'hff_ffff, thr[i]});
         check_reg("threshold", `OFS_SOF_THRESH, {24'h0, thr[i]});
      end
      reg_write(`OFS_FRAME_HIGH, 32'h7);
      check_reg("frame high ro", `OFS_FRAME_HIGH, 32'h0);
      // received markers load the frame number
      eng.send_marker(11'h5a3);
      check_reg("frame low", `OFS_FRAME_LOW, 32'ha3);
      check_reg("frame high", `OFS_FRAME_HIGH, 32'h5);
      eng.send_marker(11'h7ff);
      check_reg("frame high max", `OFS_FRAME_HIGH, 32'h7);
      // table base pieces
      reg_write(`OFS_BASE_LOW, 32'hffff_ff5b);
      reg_write(`OFS_BASE_MID, 32'h0000_00c3);
      reg_write(`OFS_BASE_TOP, 32'h0000_00a5);
      check_reg("base low", `OFS_BASE_LOW, 32'h5a);
      check_reg("base mid", `OFS_BASE_MID, 32'hc3);
      check_reg("base top", `OFS_BASE_TOP, 32'ha5);
      // every token type, low speed to device 5
      reg_write(`OFS_HOST_CTRL, 32'h1);
      reg_write(`OFS_HOST_ADDR, 32'h85);
      foreach (pids[i])
      begin
         done_delay <= 8'(4 + i * 20);
         reg_write(`OFS_TOKEN_CMD, {24'h0, pids[i], eps[i]});
         check_reg("busy", `OFS_HOST_STATUS, 32'h1);
         wait_idle();
         `CHK("pid", pids[i], last_tok.pid)
         `CHK("endpoint", eps[i], last_tok.endpoint)
         `CHK("dev addr", 7'h05, last_tok.dev_addr)
         `CHK("low speed", 1'b1, last_tok.low_speed)
         `CHK("table base", 32'ha5c3_5a00, last_tok.table_base)
         `CHK("launches", 8'(i + 1), launch_count)
         check_reg("token", `OFS_TOKEN_CMD, {24'h0, pids[i], eps[i]});
      end
      // a token written while busy is ignored; full speed now
      reg_write(`OFS_HOST_ADDR, 32'h05);
      done_delay <= 8'h3c;
      reg_write(`OFS_TOKEN_CMD, 32'h99);
      reg_write(`OFS_TOKEN_CMD, 32'hd2);
      wait_idle();
      `CHK("busy launches", 8'h04, launch_count)
      `CHK("busy endpoint", 4'h9, last_tok.endpoint)
      `CHK("full speed", 1'b0, last_tok.low_speed)
      check_reg("token kept", `OFS_TOKEN_CMD, 32'h99);
      // guard window wider than the frame holds the token back
      reg_write(`OFS_SOF_THRESH, 32'hff);
      reg_write(`OFS_HOST_CTRL, 32'h3);
      reg_write(`OFS_TOKEN_CMD, 32'h91);
      p0 = sof_pulses;
      repeat (800) @(posedge clock);
      `CHK("markers sent", 2, sof_pulses - p0)
      `CHK("held back", 8'h04, launch_count)
      // sent markers are numbered from zero and load the frame registers
      `CHK("sent number", 11'h002, sof_number)
      check_reg("sent frame low", `OFS_FRAME_LOW, 32'h1);
      check_reg("sent frame high", `OFS_FRAME_HIGH, 32'h0);
      reg_write(`OFS_HOST_CTRL, 32'h1);
      wait_idle();
      `CHK("released", 8'h05, launch_count)
      `CHK("released pid", `TOK_TYPE_IN, last_tok.pid)
      // reset in mid run returns the token, threshold, base low and frame low registers to zero
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      check_reg("token after reset", `OFS_TOKEN_CMD, 32'h0);
      check_reg("threshold after reset", `OFS_SOF_THRESH, 32'h0);
      check_reg("base after reset", `OFS_BASE_LOW, 32'h0);
      check_reg("frame after reset", `OFS_FRAME_LOW, 32'h0);
      report_and_stop();
   end
endmodule
